/* File: logic/pm_timer_pkg.sv */
// Package: register map, field layout, reset values and timing constants of the timer
package pm_timer_pkg;
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_PERIOD = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h3;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h4;
  localparam int CTRL_POST_LSB = 3;
  localparam int CTRL_POST_MSB = 6;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_PRE_LSB = 0;
  localparam int CTRL_PRE_MSB = 1;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV16 = 2'h2;
  localparam logic [1:0] PRE_DIV64 = 2'h3;
  localparam logic [5:0] PRE_TOP1 = 6'h00;
  localparam logic [5:0] PRE_TOP4 = 6'h03;
  localparam logic [5:0] PRE_TOP16 = 6'h0F;
  localparam logic [5:0] PRE_TOP64 = 6'h3F;
  localparam int IRQ_MATCH_BIT = 0;
  localparam real CLK_PERIOD_NS = 10.0;
endpackage

/* File: logic/pm_prescaler.sv */
// Module: clock prescaler that produces a one-cycle advance enable
`timescale 1ns/10ps
module pm_prescaler (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Control
  input wire logic enable_in,
  input wire logic clear_in,
  input wire logic [1:0] select_in,
  // Enable pulse
  output logic tick_out
);
  logic [5:0] pre_cnt_r;
  logic [5:0] pre_cnt_nxt;
  logic [5:0] top;
  logic at_top;

  assign top = (select_in == pm_timer_pkg::PRE_DIV64) ? pm_timer_pkg::PRE_TOP64 :
               (select_in == pm_timer_pkg::PRE_DIV16) ? pm_timer_pkg::PRE_TOP16 :
               (select_in == pm_timer_pkg::PRE_DIV4) ? pm_timer_pkg::PRE_TOP4 :
               pm_timer_pkg::PRE_TOP1;
  assign at_top = (pre_cnt_r >= top);
  assign tick_out = enable_in && !clear_in && at_top;
  assign pre_cnt_nxt = (clear_in || at_top) ? 6'h00 : 6'(pre_cnt_r + 6'h01);

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_cnt_r <= 6'h00;
    end else if (clear_in || enable_in) begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end
endmodule // pm_prescaler

/* File: logic/period_match_timer.sv */
// Module: 8-bit period-match timer with prescaler, postscaler and interrupt
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Nothing advances while sleep is asserted.
// - Count and period hold through sleep.
// - Control bit seven always reads zero.
// - Bits six to three pick postscale n+1.
// - Bit two runs or stops timer.
// - Prescale codes divide by 1, 4, 16, 64.
// - Own readable, writable count and period registers.
// - Match resets count next cycle, pulses output.
// - Postscaler sets flag; enable gates request.
// - Count/control writes, reset clear both scalers.
// - Reset clears count, period becomes all ones.
module period_match_timer (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Processor state
  input wire logic sleep_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Timer outputs
  output logic match_out,
  output logic irq_out
);
  logic [7:0] control_r;
  logic [7:0] period_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [3:0] post_cnt_r;
  logic [3:0] post_cnt_nxt;
  logic irq_status_r;
  logic irq_mask_r;
  logic match_r;
  logic irq_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic wr_control;
  logic wr_period;
  logic wr_count;
  logic wr_status;
  logic wr_mask;
  logic scaler_clear;
  logic running;
  logic tick;
  logic is_match;
  logic post_done;
  logic irq_set;
  logic irq_clr;
  logic [3:0] post_sel;

  default clocking checks_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  assign wr_control = reg_wr_in && (reg_addr_in == pm_timer_pkg::OFS_CONTROL);
  assign wr_period = reg_wr_in && (reg_addr_in == pm_timer_pkg::OFS_PERIOD);
  assign wr_count = reg_wr_in && (reg_addr_in == pm_timer_pkg::OFS_COUNT);
  assign wr_status = reg_wr_in && (reg_addr_in == pm_timer_pkg::OFS_IRQ_STATUS);
  assign wr_mask = reg_wr_in && (reg_addr_in == pm_timer_pkg::OFS_IRQ_MASK);
  assign scaler_clear = wr_count || wr_control;
  assign running = control_r[pm_timer_pkg::CTRL_RUN_BIT] && !sleep_in;
  assign post_sel = control_r[pm_timer_pkg::CTRL_POST_MSB:pm_timer_pkg::CTRL_POST_LSB];

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      control_r <= pm_timer_pkg::RST_CONTROL;
    end else if (wr_control) begin
      control_r <= reg_wdata_in & pm_timer_pkg::CTRL_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      period_r <= pm_timer_pkg::RST_PERIOD;
    end else if (wr_period) begin
      period_r <= reg_wdata_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler
  pm_prescaler i_pm_prescaler (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .enable_in(running),
    .clear_in(scaler_clear),
    .select_in(control_r[pm_timer_pkg::CTRL_PRE_MSB:pm_timer_pkg::CTRL_PRE_LSB]),
    .tick_out(tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Counter and comparator
  // Compare is against the live period, so a period write below count lets it wrap through FFh
  assign is_match = tick && (count_r == period_r);
  assign count_nxt = wr_count ? reg_wdata_in :
                     is_match ? pm_timer_pkg::RST_COUNT :
                     tick ? 8'(count_r + 8'h01) : count_r;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_r <= pm_timer_pkg::RST_COUNT;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      match_r <= 1'b0;
    end else begin
      match_r <= is_match;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Postscaler and interrupt
  assign post_done = is_match && (post_cnt_r >= post_sel);
  assign post_cnt_nxt = scaler_clear ? 4'h0 :
                        post_done ? 4'h0 :
                        is_match ? 4'(post_cnt_r + 4'h1) : post_cnt_r;
  assign irq_set = post_done && !scaler_clear;
  // Set wins over a write-one clear in the same cycle
  assign irq_clr = wr_status && reg_wdata_in[pm_timer_pkg::IRQ_MATCH_BIT];

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      post_cnt_r <= 4'h0;
    end else begin
      post_cnt_r <= post_cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_status_r <= 1'b0;
    end else if (irq_set) begin
      irq_status_r <= 1'b1;
    end else if (irq_clr) begin
      irq_status_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_mask_r <= 1'b0;
    end else if (wr_mask) begin
      irq_mask_r <= reg_wdata_in[pm_timer_pkg::IRQ_MATCH_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (irq_status_r || irq_set) && irq_mask_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port
  assign rdata_nxt = (reg_addr_in == pm_timer_pkg::OFS_CONTROL) ? {1'b0, control_r[6:0]} :
                     (reg_addr_in == pm_timer_pkg::OFS_PERIOD) ? period_r :
                     (reg_addr_in == pm_timer_pkg::OFS_COUNT) ? count_r :
                     (reg_addr_in == pm_timer_pkg::OFS_IRQ_STATUS) ? {7'h00, irq_status_r} :
                     (reg_addr_in == pm_timer_pkg::OFS_IRQ_MASK) ? {7'h00, irq_mask_r} :
                     8'h00;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign match_out = match_r;
  assign irq_out = irq_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence sleeping_s;
    sleep_in && !reg_wr_in;
  endsequence

  sequence tick_step_s;
    tick && !is_match && !wr_count;
  endsequence

  sequence doze_s;
    sleeping_s ##1 sleeping_s;
  endsequence

  sleep_hold_a: assert property (
    sleeping_s |=> $stable(count_r) && $stable(period_r))
    else $error("count or period moved during sleep");

  sleep_nomatch_a: assert property (
    sleep_in |=> !match_out)
    else $error("match during sleep");

  ctrl_top_a: assert property (
    reg_rd_in && reg_addr_in == pm_timer_pkg::OFS_CONTROL |=> !reg_rdata_out[7])
    else $error("control bit seven read as one");

  stop_hold_a: assert property (
    !control_r[2] && !reg_wr_in |=> $stable(count_r))
    else $error("count moved while stopped");

  div1_step_a: assert property (
    control_r[2] && control_r[1:0] == 2'h0 && !sleep_in && !reg_wr_in
    && count_r != period_r |=> count_r == $past(count_r) + 8'h01)
    else $error("divide by one did not step");

  match_clear_a: assert property (
    is_match && !reg_wr_in |=> count_r == 8'h00 && match_out)
    else $error("match did not clear count");

  post_one_a: assert property (
    is_match && post_sel == 4'h0 && !scaler_clear |=> irq_status_r)
    else $error("one to one postscale missed flag");

  irq_gate_a: assert property (
    irq_status_r && !irq_mask_r |=> !irq_out)
    else $error("masked flag raised interrupt");

  ctrl_keep_a: assert property (
    wr_control |=> count_r == $past(count_r) && post_cnt_r == 4'h0)
    else $error("control write disturbed count or kept postscaler");

  count_wr_a: assert property (
    wr_count |=> count_r == $past(reg_wdata_in))
    else $error("count write lost");

  rst_val_a: assert property (
    $rose(arst_n_in) |-> count_r == 8'h00 && period_r == 8'hFF)
    else $error("reset values wrong");

  prescale_64_a: assert property (
    control_r[2] && control_r[1:0] == 2'h3 && tick
    |=> (!tick || control_r[1:0] != pm_timer_pkg::PRE_DIV64) [*8])
    else $error("divide by 64 ticked early");

  wr_period_a: assert property (
    wr_period |=> period_r == $past(reg_wdata_in))
    else $error("period write lost");

  per_hold_a: assert property (
    !wr_period |=> $stable(period_r))
    else $error("period moved without a write");

  tick_step_a: assert property (
    tick_step_s |=> count_r == 8'($past(count_r) + 8'h01))
    else $error("count did not step on tick");

  no_tick_hold_a: assert property (
    !tick && !wr_count |=> $stable(count_r))
    else $error("count moved without tick");

  sleep_tick_a: assert property (
    sleep_in |-> !tick)
    else $error("tick during sleep");

  sleep_pre_a: assert property (
    sleep_in && !scaler_clear |=> $stable(i_pm_prescaler.pre_cnt_r))
    else $error("prescaler moved during sleep");

  sleep_post_a: assert property (
    sleep_in && !scaler_clear |=> $stable(post_cnt_r))
    else $error("postscaler moved during sleep");

  doze_hold_a: assert property (
    doze_s |=> count_r == $past(count_r, 2))
    else $error("count drifted across sleep");

  ctrl_rd_a: assert property (
    reg_rd_in && reg_addr_in == pm_timer_pkg::OFS_CONTROL
    |=> reg_rdata_out == {1'b0, $past(control_r[6:0])})
    else $error("control read wrong");

  per_rd_a: assert property (
    reg_rd_in && reg_addr_in == pm_timer_pkg::OFS_PERIOD
    |=> reg_rdata_out == $past(period_r))
    else $error("period read wrong");

  idle_rd_a: assert property (
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data without read");

  ctrl_wr_a: assert property (
    wr_control |=> control_r == ($past(reg_wdata_in) & pm_timer_pkg::CTRL_WRITE_MASK))
    else $error("control write wrong");

  scaler_clr_a: assert property (
    scaler_clear |=> post_cnt_r == 4'h0 && i_pm_prescaler.pre_cnt_r == 6'h00)
    else $error("scalers not cleared");

  post_range_a: assert property (
    post_cnt_r <= post_sel)
    else $error("postscaler beyond select");

  post_count_a: assert property (
    is_match && post_cnt_r < post_sel |=> post_cnt_r == 4'($past(post_cnt_r) + 4'h1))
    else $error("postscaler missed a match");

  post_wrap_a: assert property (
    post_done |=> post_cnt_r == 4'h0 && irq_status_r)
    else $error("postscaler did not wrap and flag");

  flag_sticky_a: assert property (
    irq_status_r && !irq_clr |=> irq_status_r)
    else $error("flag dropped without clear");

  flag_clear_a: assert property (
    irq_clr && !irq_set |=> !irq_status_r)
    else $error("flag not cleared");

  irq_level_a: assert property (
    irq_status_r && irq_mask_r |=> irq_out)
    else $error("unmasked flag gave no interrupt");

  irq_off_a: assert property (
    !irq_status_r && !irq_set |=> !irq_out)
    else $error("interrupt without flag");

  status_rd_a: assert property (
    reg_rd_in && reg_addr_in == pm_timer_pkg::OFS_IRQ_STATUS
    |=> reg_rdata_out == {7'h00, $past(irq_status_r)})
    else $error("status read wrong");

  run_stop_a: assert property (
    !control_r[pm_timer_pkg::CTRL_RUN_BIT] |-> !tick)
    else $error("tick while stopped");

  div4_gap_a: assert property (
    control_r[1:0] == pm_timer_pkg::PRE_DIV4 && tick
    |=> (!tick || control_r[1:0] != pm_timer_pkg::PRE_DIV4) [*3])
    else $error("divide by four ticked early");

  div16_gap_a: assert property (
    control_r[1:0] == pm_timer_pkg::PRE_DIV16 && tick
    |=> (!tick || control_r[1:0] != pm_timer_pkg::PRE_DIV16) [*8])
    else $error("divide by sixteen ticked early");

  div1_tick_a: assert property (
    control_r[pm_timer_pkg::CTRL_RUN_BIT] && control_r[1:0] == pm_timer_pkg::PRE_DIV1
    && !sleep_in && !scaler_clear |-> tick)
    else $error("divide by one missed a tick");
endmodule // period_match_timer

/* File: bench/period_match_timer_bench.sv */
// Self-checking bench for the period match timer
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; $display("unexpected at %0t: got %0h want %0h", $time, (a), (e)); end end
////////////////////////////////////////////////////////////////////////////////
module period_match_timer_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sleep = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic match;
  logic irq;
  logic [7:0] v;
  logic [7:0] w;
  int errors = 0;
  int comparisons = 0;
  int n;

  always #5 sys_clk = ~sys_clk;

  period_match_timer i_period_match_timer (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .sleep_in(sleep),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .match_out(match), .irq_out(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_match(output int c);
    c = 0;
    @(negedge sys_clk);
    while (match !== 1'b1 && c < 5000) begin
      c++;
      @(negedge sys_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(pm_timer_pkg::OFS_PERIOD, v);
    `CHK(v, 8'hFF)
    rd_reg(pm_timer_pkg::OFS_COUNT, v);
    `CHK(v, 8'h00)
    rd_reg(3'h5, v);
    `CHK(v, 8'h00)
    $display("reset test done");
  endtask

  task automatic t_regs;
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'hFF);
    rd_reg(pm_timer_pkg::OFS_CONTROL, v);
    `CHK(v, 8'h7F)
    wr_reg(pm_timer_pkg::OFS_PERIOD, 8'h3C);
    rd_reg(pm_timer_pkg::OFS_PERIOD, v);
    `CHK(v, 8'h3C)
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h00);
    wr_reg(pm_timer_pkg::OFS_COUNT, 8'hA5);
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h03);
    rd_reg(pm_timer_pkg::OFS_COUNT, v);
    `CHK(v, 8'hA5)
    $display("register test done");
  endtask

  // Gap between match pulses is (period + 1) times the divider
  task automatic t_prescale;
    wr_reg(pm_timer_pkg::OFS_PERIOD, 8'h02);
    for (int k = 0; k < 4; k++) begin
      wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h04 | 8'(k));
      wait_match(n);
      wait_match(n);
      `CHK(n, 3 * (1 << (2 * k)) - 1)
    end
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h00);
    rd_reg(pm_timer_pkg::OFS_COUNT, v);
    repeat (20) @(posedge sys_clk);
    rd_reg(pm_timer_pkg::OFS_COUNT, w);
    `CHK(w, v)
    $display("prescale test done");
  endtask

  task automatic t_postscale;
    int c;
    int g;
    int codes[3] = '{0, 3, 15};
    wr_reg(pm_timer_pkg::OFS_PERIOD, 8'h01);
    wr_reg(pm_timer_pkg::OFS_IRQ_MASK, 8'h01);
    foreach (codes[i]) begin
      wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h00);
      wr_reg(pm_timer_pkg::OFS_IRQ_STATUS, 8'h01);
      wr_reg(pm_timer_pkg::OFS_COUNT, 8'h00);
      wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h04 | 8'(codes[i] << 3));
      c = 0;
      g = 0;
      // Flag and interrupt rise at the edge of the last match pulse
      do begin
        @(negedge sys_clk);
        if (match === 1'b1) c++;
        g++;
      end while (irq !== 1'b1 && g < 500);
      `CHK(irq, 1'b1)
      `CHK(c, codes[i] + 1)
    end
    // Masked: the flag still latches but the request stays low
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h00);
    wr_reg(pm_timer_pkg::OFS_IRQ_STATUS, 8'h01);
    wr_reg(pm_timer_pkg::OFS_IRQ_MASK, 8'h00);
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h04);
    repeat (10) @(negedge sys_clk);
    `CHK(irq, 1'b0)
    rd_reg(pm_timer_pkg::OFS_IRQ_STATUS, v);
    `CHK(v, 8'h01)
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h00);
    wr_reg(pm_timer_pkg::OFS_IRQ_STATUS, 8'h01);
    rd_reg(pm_timer_pkg::OFS_IRQ_STATUS, v);
    `CHK(v, 8'h00)
    $display("postscale test done");
  endtask

  task automatic t_sleep;
    wr_reg(pm_timer_pkg::OFS_PERIOD, 8'hFF);
    wr_reg(pm_timer_pkg::OFS_CONTROL, 8'h04);
    @(posedge sys_clk);
    sleep <= 1'b1;
    rd_reg(pm_timer_pkg::OFS_COUNT, v);
    repeat (30) @(posedge sys_clk);
    rd_reg(pm_timer_pkg::OFS_COUNT, w);
    `CHK(w, v)
    rd_reg(pm_timer_pkg::OFS_PERIOD, w);
    `CHK(w, 8'hFF)
    @(posedge sys_clk);
    sleep <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd_reg(pm_timer_pkg::OFS_COUNT, w);
    `CHK(w, 8'(v + 8'h06))
    $display("sleep test done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Tests need about a thousand cycles; the limit leaves ample margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict;
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset;
    t_regs;
    t_prescale;
    t_postscale;
    t_sleep;
    give_verdict;
  end
endmodule // period_match_timer_bench
